// ===== src/cirb_pkg.sv
// Constants shared by the camera inquiry register bank files.
`default_nettype none
package cirb_pkg;
  // Fixed lower 48 bits of the register space: bus and node id fill the top 16 bits.
  localparam logic [47:0] CIRB_BASE_ADDR = 48'hFFFF_F0F0_0000;
  localparam int CIRB_ID_W = 16;
  localparam int CIRB_OFS_W = 12;
  // Byte offsets from the base address.
  localparam logic [11:0] CIRB_OFS_REINIT = 12'h000;
  localparam logic [11:0] CIRB_OFS_FMT = 12'h100;
  localparam logic [11:0] CIRB_OFS_FMT0_MODE = 12'h180;
  localparam logic [11:0] CIRB_OFS_FMT1_MODE = 12'h184;
  localparam logic [11:0] CIRB_OFS_FMT2_MODE = 12'h188;
  localparam logic [11:0] CIRB_OFS_FMT7_MODE = 12'h19C;
  // Field position in msb-first numbering; bit 0 maps to vector bit 31.
  localparam int CIRB_REINIT_BIT = 0;
  // Inquiry contents, msb-first bit 0 is vector bit 31.
  localparam logic [31:0] CIRB_FMT_MONO = 32'hE100_0000;
  localparam logic [31:0] CIRB_FMT_COLOR = 32'hE100_0000;
  localparam logic [31:0] CIRB_FMT0_MONO = 32'h4600_0000;
  localparam logic [31:0] CIRB_FMT0_COLOR = 32'h5600_0000;
  localparam logic [31:0] CIRB_FMT1_MONO = 32'h2700_0000;
  localparam logic [31:0] CIRB_FMT1_COLOR = 32'hB700_0000;
  localparam logic [31:0] CIRB_FMT2_MONO = 32'h2200_0000;
  localparam logic [31:0] CIRB_FMT2_COLOR = 32'hA200_0000;
  localparam logic [31:0] CIRB_FMT7_MONO = 32'h8000_0000;
  localparam logic [31:0] CIRB_FMT7_COLOR = 32'hC000_0000;
  localparam logic [31:0] CIRB_ZERO = 32'h0000_0000;
  localparam logic [5:0] CIRB_MAX_BLOCK_QUADS = 6'h20;
  localparam logic [1:0] CIRB_FACTORY_CHAN = 2'h0;
  typedef enum logic [1:0] {
    CIRB_ST_IDLE = 2'b00,
    CIRB_ST_PULSE = 2'b01,
    CIRB_ST_WAIT = 2'b11
  } cirb_state_t;
endpackage
`default_nettype wire

// ===== src/cirb_dec_if.sv
// Decoder-to-bank carrier between the register bank modules.
`default_nettype none
interface cirb_dec_if;
  logic hit;
  logic [3:0] sel;
  modport dec(output hit, output sel);
  modport bank(input hit, input sel);
endinterface
`default_nettype wire

// ===== src/cirb_addr_dec.sv
// Address decoder for the inquiry register bank.
`default_nettype none
module cirb_addr_dec
  import cirb_pkg::*;
(
  // Request address.
  input wire logic [47:0] addr_in,
  input wire logic [15:0] own_id_in,
  // Decoded select.
  cirb_dec_if.dec dec
);
  logic in_space;
  assign in_space = (addr_in[47:32] == own_id_in) &&
                    (addr_in[31:CIRB_OFS_W] == CIRB_BASE_ADDR[31:CIRB_OFS_W]);
  always_comb begin
    dec.sel = 4'h0;
    if (in_space) begin
      case (addr_in[11:0])
        CIRB_OFS_REINIT: dec.sel = 4'h1;
        CIRB_OFS_FMT: dec.sel = 4'h2;
        CIRB_OFS_FMT0_MODE: dec.sel = 4'h3;
        CIRB_OFS_FMT1_MODE: dec.sel = 4'h4;
        CIRB_OFS_FMT2_MODE: dec.sel = 4'h5;
        CIRB_OFS_FMT7_MODE: dec.sel = 4'h6;
        default: dec.sel = 4'h0;
      endcase
    end
  end
  assign dec.hit = in_space;
endmodule
`default_nettype wire

// ===== src/cirb_reinit_seq.sv
// Reinitialize sequencer: one-cycle reset pulse and startup channel reload.
`default_nettype none
module cirb_reinit_seq
  import cirb_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Trigger and handshake.
  input wire logic trig_in,
  input wire logic load_done_in,
  input wire logic [1:0] startup_chan_in,
  // Outputs.
  output logic busy_out,
  output logic reset_pulse_out,
  output logic load_req_out,
  output logic [1:0] load_chan_out
);
  cirb_state_t state_ff;
  cirb_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CIRB_ST_IDLE: if (trig_in) nxt_state = CIRB_ST_PULSE;
      CIRB_ST_PULSE: nxt_state = CIRB_ST_WAIT;
      CIRB_ST_WAIT: if (load_done_in) nxt_state = CIRB_ST_IDLE;
      default: nxt_state = CIRB_ST_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state_ff <= CIRB_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      reset_pulse_out <= 1'b0;
      load_req_out <= 1'b0;
      load_chan_out <= CIRB_FACTORY_CHAN;
    end else begin
      reset_pulse_out <= (nxt_state == CIRB_ST_PULSE);
      load_req_out <= (nxt_state == CIRB_ST_PULSE);
      if (nxt_state == CIRB_ST_PULSE) begin
        load_chan_out <= startup_chan_in;
      end
    end
  end
  assign busy_out = (state_ff != CIRB_ST_IDLE);
endmodule
`default_nettype wire

// ===== src/cirb_top.sv
// Camera inquiry register bank: quadlet and block access, inquiry constants, reinitialize.
//
// Overview of operation
// - Base is bus id, node id, FFFFF0F00000.
// - Register address is base plus byte offset.
// - Bit 0 is the most significant bit.
// - Writing initialize bit resets, unlocks, reloads startup.
// - Initialize bit clears itself after triggering.
// - Format register: one bit per supported format.
// - Bits 0,1,2 VGA/SVGA, 6 still, 7 partial.
// - Formats 0,1,2,7 supported, format 6 not.
// - Mode registers at 180, 184, 188, 19C.
// - Format 0: modes 1,5,6; colour adds 3.
// - Format 1: modes 2,5,6,7; colour adds 0,3.
// - Format 2: modes 2,6; colour adds 0.
// - Format 7: mode 0; colour adds 1.
// - Unmapped reads return zero; writes ignored.
// - Block transfers carry at most 32 quadlets.
// - Default reload is factory channel 0.
`default_nettype none
module cirb_top
  import cirb_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Variant strap: 1 for the colour variant.
  input wire logic color_variant_in,
  // Own bus and node identifier.
  input wire logic [15:0] own_id_in,
  // Quadlet access port, one quadlet per cycle when valid.
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_first_in,
  input wire logic [47:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  // Read answer.
  output logic rsp_valid_out,
  output logic [31:0] rsp_rdata_out,
  output logic rsp_error_out,
  // Reinitialization towards the camera core.
  input wire logic [1:0] startup_chan_in,
  input wire logic load_done_in,
  output logic core_reset_out,
  output logic lock_release_out,
  output logic load_req_out,
  output logic [1:0] load_chan_out,
  output logic reinit_busy_out
);
  ////////////////////////////////////////////////////////////////////////////////
  cirb_dec_if dec_if ();
  logic color_ff;
  logic [5:0] quad_cnt_ff;
  logic reinit_bit_ff;
  logic busy;
  logic seq_pulse;
  logic seq_load;
  logic [1:0] seq_chan;
  logic trig;
  logic over_limit;
  logic [31:0] nxt_rdata;
  logic [5:0] nxt_quad_cnt;

  cirb_addr_dec u_dec (
    .addr_in(req_addr_in),
    .own_id_in(own_id_in),
    .dec(dec_if.dec)
  );

  // The variant is a strap; catch it while reset is applied.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      color_ff <= color_variant_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Quadlet counter inside one block transfer; quadlets beyond the limit are dropped.
  always_comb begin
    nxt_quad_cnt = quad_cnt_ff;
    if (req_valid_in) begin
      if (req_first_in) begin
        nxt_quad_cnt = 6'h01;
      end else if (quad_cnt_ff != 6'h3F) begin
        nxt_quad_cnt = quad_cnt_ff + 6'h01;
      end
    end
  end
  assign over_limit = req_valid_in && !req_first_in &&
                      (quad_cnt_ff >= CIRB_MAX_BLOCK_QUADS);
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      quad_cnt_ff <= 6'h00;
    end else begin
      quad_cnt_ff <= nxt_quad_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Initialize: only msb-first bit 0 is honoured, other bits are ignored.
  assign trig = req_valid_in && req_write_in && !over_limit && (dec_if.sel == 4'h1) &&
                req_wdata_in[31 - CIRB_REINIT_BIT] && !busy &&
                !reinit_bit_ff;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      reinit_bit_ff <= 1'b0;
    end else if (trig) begin
      reinit_bit_ff <= 1'b1;
    end else begin
      reinit_bit_ff <= 1'b0;
    end
  end

  cirb_reinit_seq u_seq (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .trig_in(reinit_bit_ff),
    .load_done_in(load_done_in),
    .startup_chan_in(startup_chan_in),
    .busy_out(busy),
    .reset_pulse_out(seq_pulse),
    .load_req_out(seq_load),
    .load_chan_out(seq_chan)
  );

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      core_reset_out <= 1'b0;
      lock_release_out <= 1'b0;
      load_req_out <= 1'b0;
      load_chan_out <= CIRB_FACTORY_CHAN;
      reinit_busy_out <= 1'b0;
    end else begin
      core_reset_out <= seq_pulse;
      lock_release_out <= seq_pulse;
      load_req_out <= seq_load;
      load_chan_out <= seq_chan;
      reinit_busy_out <= busy || reinit_bit_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data; the initialize bit reads back zero once it has cleared.
  always_comb begin
    nxt_rdata = CIRB_ZERO;
    case (dec_if.sel)
      4'h1: nxt_rdata = {reinit_bit_ff, 31'h0000_0000};
      4'h2: nxt_rdata = color_ff ? CIRB_FMT_COLOR : CIRB_FMT_MONO;
      4'h3: nxt_rdata = color_ff ? CIRB_FMT0_COLOR : CIRB_FMT0_MONO;
      4'h4: nxt_rdata = color_ff ? CIRB_FMT1_COLOR : CIRB_FMT1_MONO;
      4'h5: nxt_rdata = color_ff ? CIRB_FMT2_COLOR : CIRB_FMT2_MONO;
      4'h6: nxt_rdata = color_ff ? CIRB_FMT7_COLOR : CIRB_FMT7_MONO;
      default: nxt_rdata = CIRB_ZERO;
    endcase
    // A foreign node or bus id never reaches a register, whatever the offset.
    if (over_limit || !dec_if.hit) begin
      nxt_rdata = CIRB_ZERO;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= CIRB_ZERO;
      rsp_error_out <= 1'b0;
    end else begin
      rsp_valid_out <= req_valid_in;
      rsp_rdata_out <= (req_valid_in && !req_write_in) ? nxt_rdata : CIRB_ZERO;
      rsp_error_out <= over_limit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_FMT_READ: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    req_valid_in && !req_write_in && !over_limit && dec_if.sel == 4'h2
    |=> rsp_rdata_out == 32'hE100_0000) else $error("format inquiry value wrong");
  AST_FMT0_READ: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    req_valid_in && !req_write_in && !over_limit && dec_if.sel == 4'h3
    |=> rsp_rdata_out[31:24] == (color_ff ? 8'h56 : 8'h46)) else $error("fmt0 modes wrong");
  AST_FMT1_READ: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    req_valid_in && !req_write_in && !over_limit && dec_if.sel == 4'h4
    |=> rsp_rdata_out[31:24] == (color_ff ? 8'hB7 : 8'h27)) else $error("fmt1 modes wrong");
  AST_FMT2_READ: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    req_valid_in && !req_write_in && !over_limit && dec_if.sel == 4'h5
    |=> rsp_rdata_out[31:24] == (color_ff ? 8'hA2 : 8'h22)) else $error("fmt2 modes wrong");
  AST_FMT7_READ: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    req_valid_in && !req_write_in && !over_limit && dec_if.sel == 4'h6
    |=> rsp_rdata_out[31:24] == (color_ff ? 8'hC0 : 8'h80)) else $error("fmt7 modes wrong");
  AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    req_valid_in && dec_if.sel == 4'h0 |=> rsp_rdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_INIT_SELF_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    trig |=> reinit_bit_ff ##1 !reinit_bit_ff) else $error("initialize bit stuck");
  AST_INIT_RESET: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    trig |-> ##3 (core_reset_out && lock_release_out && load_req_out))
    else $error("reinit pulse missing");
  AST_BLOCK_LIMIT: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    req_valid_in && req_write_in && over_limit |-> !trig) else $error("overlong block wrote");
  AST_LOAD_CHAN: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(load_req_out) |-> load_chan_out == $past(startup_chan_in, 3))
    else $error("wrong startup channel");
endmodule
`default_nettype wire

// ===== tb/cirb_core_model.sv
// Camera core stand-in that answers reload requests after a chosen delay.
`default_nettype none
module cirb_core_model (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic load_req_in,
  input wire logic [7:0] delay_in,
  output logic load_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  initial load_done_out = 1'b0;
  // A long delay keeps the bank busy so that a second trigger can be tried meanwhile.
  always @(posedge sys_clk_in) begin
    load_done_out <= 1'b0;
    if (!rst_b_in) cnt <= 0;
    else if (load_req_in) cnt <= delay_in + 1;
    else if (cnt == 1) begin
      load_done_out <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the camera inquiry register bank.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cirb_pkg::*;
  logic clk, rst_b, color, vld, wr, first, rv, re, done, core_rst, unlock, lreq, busy;
  logic [15:0] own_id;
  logic [47:0] addr;
  logic [31:0] wdata, rd;
  logic [1:0] chan, lchan;
  logic [7:0] dly;
  int err_count, num_checks;
  cirb_top DUT (.sys_clk_in(clk), .rst_b_in(rst_b), .color_variant_in(color),
    .own_id_in(own_id), .req_valid_in(vld), .req_write_in(wr), .req_first_in(first),
    .req_addr_in(addr), .req_wdata_in(wdata), .rsp_valid_out(rv), .rsp_rdata_out(rd),
    .rsp_error_out(re), .startup_chan_in(chan), .load_done_in(done),
    .core_reset_out(core_rst), .lock_release_out(unlock), .load_req_out(lreq),
    .load_chan_out(lchan), .reinit_busy_out(busy));
  cirb_core_model core (.sys_clk_in(clk), .rst_b_in(rst_b), .load_req_in(lreq),
    .delay_in(dly), .load_done_out(done));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Values written here from the mode lists, msb-first, not from the package.
  function automatic logic [31:0] exp_rd(input logic [47:0] a);
    if (a[47:12] !== {own_id, 20'hF0F00}) return 32'h0;
    case (a[11:0])
      12'h100: return 32'hE100_0000;
      12'h180: return color ? 32'h5600_0000 : 32'h4600_0000;
      12'h184: return color ? 32'hB700_0000 : 32'h2700_0000;
      12'h188: return color ? 32'hA200_0000 : 32'h2200_0000;
      12'h19C: return color ? 32'hC000_0000 : 32'h8000_0000;
      default: return 32'h0;
    endcase
  endfunction
  // Back-to-back quadlets; each answer is checked just after the edge that takes its quadlet.
  task automatic xfer(input logic w, input int n, input logic [47:0] a0, input logic [31:0] d);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      vld <= (i < n);
      wr <= w;
      first <= (i == 0);
      addr <= a0 + 48'(4 * i);
      wdata <= d;
      #1;
      if (i > 0) begin
        chk("rsp_valid", {31'h0, rv}, 32'h1);
        chk("rsp_rdata", rd, (w || i > 32) ? 32'h0 : exp_rd(a0 + 48'(4 * (i - 1))));
        chk("rsp_error", {31'h0, re}, {31'h0, i > 32});
      end
    end
  endtask
  task automatic reinit(input logic [31:0] d);
    int k;
    @(posedge clk);
    chan <= 2'($urandom);
    dly <= 8'($urandom_range(10, 30));
    xfer(1'b1, 1, {own_id, 32'hF0F0_0000}, d);
    k = 0;
    while (lreq !== 1'b1 && k < 6) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("reinit_delay", 32'(k), d[31] ? 32'h2 : 32'h6);
    if (d[31]) begin
      chk("core_reset", {31'h0, core_rst}, 32'h1);
      chk("lock_release", {31'h0, unlock}, 32'h1);
      chk("load_chan", {30'h0, lchan}, {30'h0, chan});
      chk("busy", {31'h0, busy}, 32'h1);
      xfer(1'b1, 1, {own_id, 32'hF0F0_0000}, d);
      chk("one_pulse", {29'h0, core_rst, unlock, lreq}, 32'h0);
      k = 0;
      while (busy === 1'b1 && k < 80) begin
        @(posedge clk);
        #1;
        k++;
      end
      chk("busy_end", {31'h0, busy}, 32'h0);
    end
    xfer(1'b0, 1, {own_id, 32'hF0F0_0000}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    err_count++;
    results;
  end
  initial begin
    rst_b = 1'b0;
    color = 1'b0;
    own_id = 16'h0;
    vld = 1'b0;
    wr = 1'b0;
    first = 1'b0;
    addr = 48'h0;
    wdata = 32'h0;
    chan = 2'h0;
    dly = 8'h0;
    void'($urandom(32'hF627F271));
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      rst_b <= 1'b0;
      color <= v[0];
      own_id <= 16'($urandom);
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      chk("reset_out", {28'h0, rv, lreq, busy, core_rst}, 32'h0);
      xfer(1'b0, 8, {own_id, 32'hF0F0_0180}, 32'h0);
      xfer(1'b0, 33, {own_id, 32'hF0F0_0100}, 32'h0);
      xfer(1'b1, 8, {own_id, 32'hF0F0_0180}, $urandom);
      xfer(1'b1, 1, {own_id, 32'hF0F0_0100}, $urandom);
      xfer(1'b0, 8, {own_id, 32'hF0F0_0180}, 32'h0);
      xfer(1'b0, 1, {own_id, 32'hF0F0_0100}, 32'h0);
      repeat (20) xfer(1'b0, 1, {own_id, 32'hF0F0_0000} + 48'($urandom_range(0, 127) * 4),
        32'h0);
      xfer(1'b0, 1, {~own_id, 32'hF0F0_0100}, 32'h0);
      // The host rechecks the mode lists of formats 0 and 7 after the foreign-id read.
      xfer(1'b0, 1, {own_id, 32'hF0F0_0180}, 32'h0);
      xfer(1'b0, 1, {own_id, 32'hF0F0_019C}, 32'h0);
      reinit(32'h7FFF_FFFF);
      reinit(32'h8000_0000);
      reinit($urandom | 32'h8000_0000);
      $display("variant %0d test done", v);
    end
    results;
  end
endmodule
`default_nettype wire
